// File: core/pdoc_ctrl.sv
// Purpose: switching outputs, dosing control and control input decode
// Assumes: measurement flags and volume steps come from the meter core
// Notes: configuration arrives as plain ports; no register bus
`timescale 1ns/100ps
module pdoc_ctrl #(
  parameter int PULSE_MAX_N = pdoc_pkg::PULSE_MAX_CYC,
  parameter int TRIP_N = pdoc_pkg::TRIP_CYC,
  parameter int HOLD_N = pdoc_pkg::HOLD_CYC,
  parameter int SEC_N = pdoc_pkg::SEC_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic vol_tick,
  input wire pdoc_pkg::pdoc_meas_t meas,
  input wire logic undervolt,
  input wire logic overload,
  input wire logic big_variant,
  input wire logic [pdoc_pkg::PV_W-1:0] pulse_value,
  input wire logic [pdoc_pkg::VOL_W-1:0] dose_batch,
  input wire logic [pdoc_pkg::TIME_W-1:0] dose_time_s,
  input wire pdoc_pkg::pdoc_out_cfg_t out1_cfg,
  input wire pdoc_pkg::pdoc_out_cfg_t out2_cfg,
  input wire pdoc_pkg::pdoc_cfunc_t ctl_func,
  input wire logic control_input,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  output pdoc_pkg::pdoc_pin_t first_switch_output,
  output pdoc_pkg::pdoc_pin_t second_switch_output,
  output logic dosing_q,
  output logic offset_capture_q,
  output logic cutoff_disable_q,
  output logic counter_clear_q,
  output logic trip_q
);
  import pdoc_pkg::*;

  localparam logic [CNT_W-1:0] TRIP_W = CNT_W'(TRIP_N);
  localparam logic [CNT_W-1:0] HOLD_W = CNT_W'(HOLD_N);
  localparam logic [CNT_W-1:0] SEC_W = CNT_W'(SEC_N);
  localparam logic [CNT_W-1:0] ONE = 28'h000_0001;

  ////////////////////////////////////////////////////////////////////////
  // Drive decision of one output: high means the transistor conducts
  function automatic logic out_drive(input pdoc_out_cfg_t c, input pdoc_meas_t m,
                                     input logic pulse, input logic dosing,
                                     input logic seen);
    logic d;
    d = 1'b0;
    case (c.func)
      PDOC_OF_PULSE: d = pulse;
      PDOC_OF_EMPTY: d = m.empty ^ c.nc;
      PDOC_OF_DOSE: d = seen && (dosing ^ c.nc);
      PDOC_OF_LOWER: d = !m.below ^ c.nc;
      PDOC_OF_UPPER: d = !m.above ^ c.nc;
      PDOC_OF_REVERSE: d = m.reverse ^ c.nc;
      default: d = 1'b0;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Settings caught at restart
  pdoc_cfunc_t cfunc_q;
  logic big_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfunc_q <= ctl_func;
      big_q <= big_variant;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse generation
  logic [PV_W-1:0] pv_clamped;
  logic emit;
  logic pulse;

  assign pv_clamped = (pulse_value < PV_MIN) ? PV_MIN :
                      ((pulse_value > PV_MAX) ? PV_MAX : pulse_value);

  pdoc_pulse_gen #(
    .MAX_CYC(PULSE_MAX_N)
  ) u_pulse (
    .clk(clk),
    .srst(srst),
    .vol_tick(vol_tick),
    .pulse_value(pv_clamped),
    .emit(emit),
    .pulse_q(pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control input decode
  logic ctl_prev_q;
  logic ctl_rise;
  logic ctl_en;

  assign ctl_en = big_q;
  assign ctl_rise = ctl_en && control_input && !ctl_prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_prev_q <= 1'b1;
      offset_capture_q <= 1'b0;
      cutoff_disable_q <= 1'b0;
      counter_clear_q <= 1'b0;
    end else begin
      ctl_prev_q <= control_input;
      offset_capture_q <= ctl_rise && (cfunc_q == PDOC_CF_OFFSET);
      counter_clear_q <= ctl_rise && (cfunc_q == PDOC_CF_CLEAR);
      cutoff_disable_q <= ctl_en && control_input && (cfunc_q == PDOC_CF_CUTOFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dose controller
  pdoc_state_t state_q;
  pdoc_state_t state_d;
  logic [VOL_W-1:0] batch_lim;
  logic [TIME_W-1:0] time_lim;
  logic [VOL_W-1:0] dvol_q;
  logic [CNT_W-1:0] pre_q;
  logic [TIME_W-1:0] secs_q;
  logic seen_q;
  logic start_req;
  logic vol_done;
  logic time_done;
  logic dose_end;

  assign batch_lim = (dose_batch > BATCH_MAX) ? BATCH_MAX : dose_batch;
  assign time_lim = (dose_time_s > TIME_MAX) ? TIME_MAX : dose_time_s;
  assign start_req = start_cmd || (ctl_rise && (cfunc_q == PDOC_CF_DOSE));
  assign vol_done = (dvol_q >= batch_lim);
  assign time_done = (time_lim != '0) && (secs_q >= time_lim);
  assign dose_end = stop_cmd || vol_done || time_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PDOC_ST_IDLE,
      PDOC_ST_DONE: begin
        if (start_req) begin
          state_d = PDOC_ST_DOSING;
        end
      end
      PDOC_ST_DOSING: begin
        if (dose_end) begin
          state_d = PDOC_ST_DONE;
        end
      end
      default: state_d = PDOC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= PDOC_ST_IDLE;
      dvol_q <= '0;
      pre_q <= '0;
      secs_q <= '0;
      seen_q <= 1'b0;
      dosing_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dosing_q <= (state_d == PDOC_ST_DOSING);
      if (state_q != PDOC_ST_DOSING) begin
        dvol_q <= '0;
        pre_q <= '0;
        secs_q <= '0;
      end else begin
        if (vol_tick) begin
          dvol_q <= dvol_q + 26'h000_0001;
        end
        // Seconds prescaler; timeout resolution is one second
        if (pre_q >= SEC_W - ONE) begin
          pre_q <= '0;
          secs_q <= (secs_q == TIME_MAX) ? secs_q : secs_q + 15'h0001;
        end else begin
          pre_q <= pre_q + ONE;
        end
      end
      if (state_d == PDOC_ST_DOSING) begin
        seen_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overload trip and hold-off
  logic [CNT_W-1:0] ovl_q;
  logic [CNT_W-1:0] hold_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ovl_q <= '0;
      hold_q <= '0;
      trip_q <= 1'b0;
    end else if (trip_q) begin
      ovl_q <= '0;
      if (hold_q >= HOLD_W - ONE) begin
        hold_q <= '0;
        trip_q <= 1'b0;
      end else begin
        hold_q <= hold_q + ONE;
      end
    end else if (overload) begin
      if (ovl_q >= TRIP_W - ONE) begin
        trip_q <= 1'b1;
        ovl_q <= '0;
      end else begin
        ovl_q <= ovl_q + ONE;
      end
    end else begin
      ovl_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage
  pdoc_out_cfg_t cfg [2];
  pdoc_pin_t pin_q [2];
  logic present [2];

  assign cfg[0] = out1_cfg;
  assign cfg[1] = out2_cfg;
  assign present[0] = 1'b1;
  assign present[1] = big_q;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_out
      logic drv;
      assign drv = out_drive(cfg[i], meas, pulse, dosing_q, seen_q);
      always_ff @(posedge clk) begin
        if (srst) begin
          pin_q[i] <= '0;
        end else begin
          pin_q[i].oe <= present[i] && drv && !undervolt && !trip_q;
          pin_q[i].level <= cfg[i].pnp;
        end
      end
    end
  endgenerate

  assign first_switch_output = pin_q[0];
  assign second_switch_output = pin_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_uv_float;
    undervolt |=> !first_switch_output.oe && !second_switch_output.oe;
  endproperty
  a_uv_float: assert property (p_uv_float) else $error("output drives in undervolt");

  property p_trip_off;
    $rose(trip_q) |=> (!first_switch_output.oe && !second_switch_output.oe) [*8];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output on during trip");

  property p_trip_cause;
    $rose(trip_q) |-> $past(overload);
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip without overload");

  property p_no_restart;
    state_q == PDOC_ST_DOSING && !dose_end |=> state_q == PDOC_ST_DOSING;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("dose left early");

  property p_batch_stop;
    state_q == PDOC_ST_DOSING && vol_done |=> !dosing_q;
  endproperty
  a_batch_stop: assert property (p_batch_stop) else $error("dose ran past batch");

  property p_time_zero;
    state_q == PDOC_ST_DOSING && time_lim == '0 && !stop_cmd && !vol_done
      |=> dosing_q;
  endproperty
  a_time_zero: assert property (p_time_zero) else $error("timer ended dose");

  property p_float_first;
    !seen_q && out2_cfg.func == PDOC_OF_DOSE |=> !second_switch_output.oe;
  endproperty
  a_float_first: assert property (p_float_first) else $error("dose output early");

  property p_small_variant;
    !big_q |=> !second_switch_output.oe && !cutoff_disable_q && !counter_clear_q;
  endproperty
  a_small_variant: assert property (p_small_variant) else $error("absent pin active");

  property p_clear_edge;
    counter_clear_q |-> $past(control_input) && !$past(ctl_prev_q);
  endproperty
  a_clear_edge: assert property (p_clear_edge) else $error("clear without edge");

  property p_start;
    state_q == PDOC_ST_IDLE && start_req |=> dosing_q;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  c_dose_batch: cover property (dosing_q ##1 !dosing_q && $past(vol_done));
  c_trip_cycle: cover property ($fell(trip_q));
  c_pulse_out: cover property (first_switch_output.oe && out1_cfg.func == PDOC_OF_PULSE);
  c_pulse_emit: cover property (emit);

endmodule

// File: core/pdoc_pkg.sv
// Purpose: shared constants and types of the pulse and dosing output control
// Assumes: 100 MHz clock, volume arrives as 0.1 ml steps
// Notes: long cycle counts are defaults for top-level parameters
package pdoc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and times
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_MAX_MS = 1000;
  localparam int TRIP_US = 100;
  localparam int HOLD_MS = 2000;
  localparam int SEC_MS = 1000;
  localparam int PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000);
  localparam int TRIP_CYC = TRIP_US * (CLK_HZ / 1_000_000);
  localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int SEC_CYC = SEC_MS * (CLK_HZ / 1000);
  localparam int MAX_PULSE_HZ = 10_000;

  ////////////////////////////////////////////////////////////////////////
  // Widths and ranges (volume in 0.1 ml units)
  localparam int PV_W = 15;
  localparam int VOL_W = 26;
  localparam int TIME_W = 15;
  localparam int CNT_W = 28;
  localparam logic [PV_W-1:0] PV_MIN = 15'h0001;
  localparam logic [PV_W-1:0] PV_MAX = 15'h7530;
  localparam logic [PV_W-1:0] PV_DEFAULT = 15'h000A;
  localparam logic [VOL_W-1:0] BATCH_MAX = 26'h216_0EC0;
  localparam logic [VOL_W-1:0] BATCH_DEFAULT = 26'h000_0000;
  localparam logic [TIME_W-1:0] TIME_MAX = 15'h7530;
  localparam logic [TIME_W-1:0] TIME_DEFAULT = 15'h0003;

  ////////////////////////////////////////////////////////////////////////
  // Output functions, control input functions, dose states
  typedef enum logic [2:0] {
    PDOC_OF_OFF = 3'h0,
    PDOC_OF_PULSE = 3'h1,
    PDOC_OF_EMPTY = 3'h2,
    PDOC_OF_DOSE = 3'h3,
    PDOC_OF_LOWER = 3'h4,
    PDOC_OF_UPPER = 3'h5,
    PDOC_OF_REVERSE = 3'h6
  } pdoc_ofunc_t;

  typedef enum logic [2:0] {
    PDOC_CF_NONE = 3'h0,
    PDOC_CF_DOSE = 3'h1,
    PDOC_CF_OFFSET = 3'h2,
    PDOC_CF_CUTOFF = 3'h3,
    PDOC_CF_CLEAR = 3'h4
  } pdoc_cfunc_t;

  typedef enum logic [1:0] {
    PDOC_ST_IDLE = 2'b00,
    PDOC_ST_DOSING = 2'b01,
    PDOC_ST_DONE = 2'b11
  } pdoc_state_t;

  typedef struct packed {
    pdoc_ofunc_t func;
    logic nc;
    logic pnp;
  } pdoc_out_cfg_t;

  typedef struct packed {
    logic empty;
    logic below;
    logic above;
    logic reverse;
  } pdoc_meas_t;

  typedef struct packed {
    logic oe;
    logic level;
  } pdoc_pin_t;

  localparam pdoc_out_cfg_t OUT1_DEFAULT = '{PDOC_OF_PULSE, 1'b0, 1'b1};
  localparam pdoc_out_cfg_t OUT2_DEFAULT = '{PDOC_OF_EMPTY, 1'b0, 1'b1};
  localparam pdoc_cfunc_t CFUNC_DEFAULT = PDOC_CF_NONE;

endpackage

// File: core/pdoc_pulse_gen.sv
// Purpose: volume to pulse conversion with pulse width of half the period, at most MAX_CYC
// Assumes: vol_tick is one cycle per 0.1 ml
// Notes: width is taken from the previous pulse spacing
`timescale 1ns/100ps
module pdoc_pulse_gen #(
  parameter int MAX_CYC = pdoc_pkg::PULSE_MAX_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic vol_tick,
  input wire logic [pdoc_pkg::PV_W-1:0] pulse_value,
  output logic emit,
  output logic pulse_q
);
  import pdoc_pkg::*;

  localparam logic [CNT_W-1:0] MAX_W = CNT_W'(MAX_CYC);
  localparam logic [CNT_W-1:0] SAT = {CNT_W{1'b1}};

  logic [PV_W-1:0] acc_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] wid_q;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] width;
  logic [PV_W-1:0] acc_inc;

  ////////////////////////////////////////////////////////////////////////
  // count up to setting
  assign acc_inc = acc_q + 15'h0001;
  assign emit = vol_tick && (acc_inc >= pulse_value);
  assign half = per_q >> 1;
  assign width = (half > MAX_W) ? MAX_W : ((half == '0) ? 28'h000_0001 : half);

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= '0;
      per_q <= SAT;
      wid_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      if (vol_tick) begin
        acc_q <= emit ? '0 : acc_inc;
      end
      per_q <= emit ? 28'h000_0001 : ((per_q == SAT) ? SAT : per_q + 28'h000_0001);
      if (emit) begin
        wid_q <= width;
        pulse_q <= 1'b1;
      end else if (wid_q > 28'h000_0001) begin
        wid_q <= wid_q - 28'h000_0001;
      end else begin
        wid_q <= '0;
        pulse_q <= 1'b0;
      end
    end
  end

  property p_emit_pulse;
    @(posedge clk) disable iff (srst) emit |=> pulse_q;
  endproperty
  a_emit_pulse: assert property (p_emit_pulse) else $error("no pulse after emit");

endmodule

// File: testbench/pdoc_load.sv
// Purpose: far-side load of the switching outputs: pulse counter, valve, short
// Assumes: oe high means the output transistor conducts
// Notes: a short only draws current while an output conducts
`timescale 1ns/100ps
module pdoc_load (
  input wire logic clk,
  input wire pdoc_pkg::pdoc_pin_t first_switch_output,
  input wire pdoc_pkg::pdoc_pin_t second_switch_output,
  input wire logic short_en,
  output logic overload,
  output int pulse_cnt,
  output int pulse_w,
  output logic valve_open
);
  import pdoc_pkg::*;
  int w;

  ////////////////////////////////////////////////////////////////////////
  // counter takes one count per pulse
  initial begin
    pulse_cnt = 0;
    pulse_w = 0;
    w = 0;
  end
  always @(posedge clk) begin
    if (first_switch_output.oe === 1'b1) begin
      w <= w + 1;
    end else if (w != 0) begin
      pulse_cnt <= pulse_cnt + 1;
      pulse_w <= w;
      w <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // valve wired normally closed, open only while driven
  assign valve_open = second_switch_output.oe;
  // Current flows into the short only through a conducting output
  assign overload = short_en & (first_switch_output.oe | second_switch_output.oe);
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench of the pulse and dosing output control
// Assumes: shortened counts: pulse max 200, trip 10, hold 100, second 50
// Notes: inputs change on the falling edge, outputs sampled there too
`timescale 1ns/100ps
module tb;
  import pdoc_pkg::*;
  logic clk, srst, vol_tick, undervolt, overload, big_variant;
  logic control_input, start_cmd, stop_cmd, short_en, valve_open;
  logic dosing_q, offset_capture_q, cutoff_disable_q, counter_clear_q, trip_q;
  pdoc_meas_t meas;
  logic [PV_W-1:0] pulse_value;
  logic [VOL_W-1:0] dose_batch;
  logic [TIME_W-1:0] dose_time_s;
  pdoc_out_cfg_t out1_cfg, out2_cfg;
  pdoc_cfunc_t ctl_func;
  pdoc_pin_t first_switch_output, second_switch_output;
  int n_errors, n_checks, pulse_cnt, pulse_w, pv, b, p0, k1, k2;
  pdoc_ofunc_t ofs [5] = '{PDOC_OF_OFF, PDOC_OF_EMPTY, PDOC_OF_LOWER, PDOC_OF_UPPER,
                           PDOC_OF_REVERSE};
  pdoc_cfunc_t cfs [4] = '{PDOC_CF_NONE, PDOC_CF_OFFSET, PDOC_CF_CUTOFF, PDOC_CF_CLEAR};

  pdoc_ctrl #(.PULSE_MAX_N(200), .TRIP_N(10), .HOLD_N(100), .SEC_N(50)) dut (
    .clk(clk), .srst(srst), .vol_tick(vol_tick), .meas(meas), .undervolt(undervolt),
    .overload(overload), .big_variant(big_variant), .pulse_value(pulse_value),
    .dose_batch(dose_batch), .dose_time_s(dose_time_s), .out1_cfg(out1_cfg),
    .out2_cfg(out2_cfg), .ctl_func(ctl_func), .control_input(control_input),
    .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .first_switch_output(first_switch_output),
    .second_switch_output(second_switch_output), .dosing_q(dosing_q),
    .offset_capture_q(offset_capture_q), .cutoff_disable_q(cutoff_disable_q),
    .counter_clear_q(counter_clear_q), .trip_q(trip_q));

  pdoc_load ld (
    .clk(clk), .first_switch_output(first_switch_output),
    .second_switch_output(second_switch_output), .short_en(short_en),
    .overload(overload), .pulse_cnt(pulse_cnt), .pulse_w(pulse_w),
    .valve_open(valve_open));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    cyc(5);
    srst = 1'b0;
  endtask

  task automatic ticks(input int n, input int gap);
    repeat (n) begin
      vol_tick = 1'b1;
      cyc(1);
      vol_tick = 1'b0;
      cyc(gap - 1);
    end
  endtask

  // One-cycle operator command, driven on the module signal itself
  task automatic pulse_cmd(input bit stop);
    if (stop) begin
      stop_cmd = 1'b1;
    end else begin
      start_cmd = 1'b1;
    end
    cyc(1);
    {start_cmd, stop_cmd} = 2'b00;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whether an output conducts for a given function, sense and meter state
  function automatic logic exp_drive(pdoc_ofunc_t f, logic nc, pdoc_meas_t m);
    case (f)
      PDOC_OF_EMPTY: return m.empty ^ nc;
      PDOC_OF_LOWER: return !m.below ^ nc;
      PDOC_OF_UPPER: return !m.above ^ nc;
      PDOC_OF_REVERSE: return m.reverse ^ nc;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    #300_000;
    n_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_checks = 0;
    {srst, vol_tick, undervolt, big_variant} = 4'h9;
    {control_input, start_cmd, stop_cmd, short_en} = 4'h0;
    meas = '0;
    pulse_value = PV_DEFAULT;
    dose_batch = BATCH_DEFAULT;
    dose_time_s = TIME_DEFAULT;
    out1_cfg = OUT1_DEFAULT;
    out2_cfg = '{PDOC_OF_DOSE, 1'b0, 1'b1};
    ctl_func = PDOC_CF_DOSE;
    void'($urandom(32'h0000_07bf));
    do_reset();
    cyc(2);
    chk(second_switch_output.oe, 0);
    chk(first_switch_output.oe, 0);
    // Pulse spacing stays above the 200-cycle first width
    pv = 4 + $urandom % 3;
    pulse_value = pv[PV_W-1:0];
    p0 = pulse_cnt;
    ticks(3 * pv + $urandom % pv, 60);
    cyc(250);
    chk(pulse_cnt - p0, 3);
    chk(pulse_w, pv * 30);
    // Operator start, second start ignored, valve closes at batch
    dose_time_s = '0;
    b = 3 + $urandom % 6;
    dose_batch = b[VOL_W-1:0];
    pulse_cmd(1'b0);
    cyc(3);
    chk(valve_open, 1);
    ticks(b - 1, 4);
    pulse_cmd(1'b0);
    cyc(2);
    chk(dosing_q, 1);
    ticks(1, 4);
    cyc(2);
    chk(dosing_q, 0);
    chk(valve_open, 0);
    // Control input start with a second rising edge mid-dose
    control_input = 1'b1;
    cyc(3);
    chk(valve_open, 1);
    ticks(b - 1, 4);
    control_input = 1'b0;
    cyc(2);
    control_input = 1'b1;
    ticks(1, 4);
    cyc(2);
    chk(dosing_q, 0);
    control_input = 1'b0;
    // Untimed long dose, stop command, then a one second limit
    dose_batch = BATCH_MAX;
    pulse_cmd(1'b0);
    cyc(120);
    chk(dosing_q, 1);
    pulse_cmd(1'b1);
    cyc(3);
    chk(dosing_q, 0);
    dose_time_s = 15'h0001;
    pulse_cmd(1'b0);
    cyc(39);
    chk(dosing_q, 1);
    cyc(22);
    chk(dosing_q, 0);
    // Random functions, senses and meter states on both outputs
    repeat (24) begin
      out1_cfg = '{ofs[$urandom % 5], 1'($urandom), 1'($urandom)};
      out2_cfg = '{ofs[$urandom % 5], 1'($urandom), 1'($urandom)};
      meas = 4'($urandom);
      cyc(3);
      chk(first_switch_output.oe, exp_drive(out1_cfg.func, out1_cfg.nc, meas));
      chk(second_switch_output.oe, exp_drive(out2_cfg.func, out2_cfg.nc, meas));
      chk(second_switch_output.level, out2_cfg.pnp);
      chk(first_switch_output.level, out1_cfg.pnp);
    end
    out2_cfg = '{PDOC_OF_EMPTY, 1'b0, 1'b1};
    meas = 4'h8;
    cyc(3);
    chk(second_switch_output.oe, 1);
    undervolt = 1'b1;
    cyc(2);
    chk(second_switch_output.oe, 0);
    undervolt = 1'b0;
    cyc(3);
    // A short briefer than the trip time is ignored
    short_en = 1'b1;
    cyc(5);
    short_en = 1'b0;
    cyc(2);
    chk(trip_q, 0);
    short_en = 1'b1;
    cyc(14);
    chk(trip_q, 1);
    chk(second_switch_output.oe, 0);
    short_en = 1'b0;
    cyc(80);
    chk(trip_q, 1);
    cyc(30);
    chk(second_switch_output.oe, 1);
    // Input function fixed at reset; later changes have no effect
    // full, still pipe
    meas = '0;
    foreach (cfs[i]) begin
      ctl_func = cfs[i];
      do_reset();
      ctl_func = PDOC_CF_DOSE;
      cyc(2);
      control_input = 1'b1;
      k1 = 0;
      k2 = 0;
      repeat (4) begin
        cyc(1);
        if (offset_capture_q === 1'b1) k1++;
        if (counter_clear_q === 1'b1) k2++;
      end
      chk(k1, cfs[i] == PDOC_CF_OFFSET);
      chk(k2, cfs[i] == PDOC_CF_CLEAR);
      chk(cutoff_disable_q, cfs[i] == PDOC_CF_CUTOFF);
      chk(dosing_q, 0);
      control_input = 1'b0;
      cyc(3);
      chk(cutoff_disable_q, 0);
    end
    // Small variant: second output and control input absent
    big_variant = 1'b0;
    meas = 4'h8;
    do_reset();
    cyc(3);
    control_input = 1'b1;
    cyc(3);
    chk(second_switch_output.oe, 0);
    chk(dosing_q, 0);
    give_verdict();
  end
endmodule
